// file: core/mmc_map.svh
/*
 * mmc_map.svh: opcodes, status codes, addresses and sizes used by the
 * motion module command decoder.
 * assumes: included by bare name from the design files.
 */
`ifndef MMC_MAP_SVH
`define MMC_MAP_SVH

// ==========================================================
// reply addresses
`define MMC_HOST_ADDR     8'h02
`define MMC_MODULE_ADDR   8'h01

// ==========================================================
// opcodes
`define MMC_OP_UF_FIRST   8'h40
`define MMC_OP_UF_LAST    8'h47
`define MMC_OP_MOVE_POS   8'h04
`define MMC_OP_STOP       8'h80
`define MMC_OP_RUN        8'h81
`define MMC_OP_STEP       8'h82
`define MMC_OP_RESET      8'h83
`define MMC_OP_DL_ENTER   8'h84
`define MMC_OP_DL_EXIT    8'h85
`define MMC_OP_MEM_READ   8'h86
`define MMC_OP_STATUS     8'h87
`define MMC_OP_VERSION    8'h88
`define MMC_OP_FACTORY    8'h89
`define MMC_OP_POS_REQ    8'h8A
`define MMC_OP_SW_RESET   8'hFF

// ==========================================================
// status codes
`define MMC_ST_OK         8'h64
`define MMC_ST_ARRIVED    8'h80
`define MMC_ST_BAD_CKSUM  8'h01
`define MMC_ST_BAD_CMD    8'h02
`define MMC_ST_BAD_TYPE   8'h03
`define MMC_ST_BAD_VALUE  8'h04

// ==========================================================
// magic value, memory and version (version values arbitrary)
`define MMC_MAGIC         32'h000004D2
`define MMC_MEM_DEPTH     256
`define MMC_FW_STRING     64'h4D4D433130303031
`define MMC_FW_BINARY     32'h00010001

`endif

// file: core/mmc_pkg.sv
/*
 * mmc_pkg.sv: types of the motion module command decoder.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package mmc_pkg;

   typedef logic [7:0] mmc_byte_t;

   typedef enum logic [1:0] {
      MODE_STOP,
      MODE_RUN,
      MODE_STEP
   } mmc_mode_t;

endpackage

// file: core/mmc_sum8.sv
/*
 * mmc_sum8.sv: modulo-256 sum of the eight leading bytes of a frame.
 * assumes: purely combinational, used inside the command decoder.
 */
`timescale 1ns/1ns
module mmc_sum8 (
   input  wire mmc_pkg::mmc_byte_t b0,    // first byte
   input  wire mmc_pkg::mmc_byte_t b1,    // second byte
   input  wire mmc_pkg::mmc_byte_t b2,    // third byte
   input  wire mmc_pkg::mmc_byte_t b3,    // fourth byte
   input  wire logic [31:0]        val,   // value, big end first
   output logic [7:0]              sum    // checksum byte
);
   always_comb begin
      sum = 8'(b0 + b1 + b2 + b3 + val[31:24] + val[23:16]
               + val[15:8] + val[7:0]);
   end
endmodule

// file: core/mmc_ctrl.sv
/*
 * mmc_ctrl.sv: command decoder of a single-axis motion module. takes
 * whole nine-byte command frames, answers with reply frames, drives
 * the stored-program engine and arms the position-reached event.
 * assumes: frame transport outside; one 20 MHz clock; cmd inputs valid
 * in the cycle of cmd_valid; pulses are one cycle wide.
 */
// What this block does
// R1: user-function opcodes answer status OK with a user-supplied value.
// R2: position request gets an immediate reply and a later arrival reply.
// R3: position request is taken only in direct mode, never stored.
// R4: host writes motor mask 1 in the value field.
// R5: type 0 arms the arrival reply for the next move only.
// R6: type 1 keeps the arrival reply armed for every move.
// R7: immediate reply: host 02, module 01, status 100, cmd 138, mask.
// R8: arrival reply: same layout with status 128.
// R9: control commands act only directly, never stored in program memory.
// R10: host sets motor/bank to zero on control commands.
// R11: opcode 128 halts the stored program.
// R12: opcode 129 runs, type 0 from current, type 1 from given address.
// R13: opcode 130 runs exactly one instruction then stops.
// R14: opcode 131 stops and clears counter, stack, accumulator, X, flags.
// R15: opcode 132 enters download; later plain commands go to memory.
// R16: opcode 133 leaves download mode.
// R17: opcode 134 returns the addressed program memory word.
// R18: opcode 135 returns status chosen by type 0 to 3.
// R19: opcode 136 returns version as string or binary.
// R20: opcode 137 with 1234 restores factory settings, no reply.
// R21: opcode 255 with 1234 restarts the module.
// R22: frame checksum is byte sum of eight bytes; bad frames rejected.
`timescale 1ns/1ns
`include "mmc_map.svh"
module mmc_ctrl (
   input  wire logic        core_clk,        // 20 MHz clock
   input  wire logic        nrst,            // async reset, active low
   input  wire logic        cmd_valid,       // command frame present
   input  wire logic [7:0]  cmd_target,      // module address byte
   input  wire logic [7:0]  cmd_op,          // opcode
   input  wire logic [7:0]  cmd_type,        // type field
   input  wire logic [7:0]  cmd_bank,        // motor/bank field
   input  wire logic [31:0] cmd_value,       // value field
   input  wire logic [7:0]  cmd_cksum,       // checksum byte
   input  wire logic        pos_reached,     // motor at target, pulse
   input  wire logic        prog_instr_done, // one instruction done
   input  wire logic        prog_wait,       // program wait flag
   input  wire logic [15:0] prog_pc,         // program counter
   input  wire logic [31:0] prog_accu,       // accumulator
   input  wire logic [31:0] prog_xreg,       // X register
   input  wire logic [31:0] uf_value,        // user-function result
   output logic             rpl_valid,       // reply frame, pulse
   output logic [7:0]       rpl_host,        // reply byte 0
   output logic [7:0]       rpl_target,      // reply byte 1
   output logic [7:0]       rpl_status,      // reply status
   output logic [7:0]       rpl_cmd,         // reply command echo
   output logic [31:0]      rpl_value,       // reply value
   output logic [7:0]       rpl_cksum,       // reply checksum
   output logic             prog_run,        // program engine runs
   output logic             prog_load,       // load pc, pulse
   output logic [15:0]      prog_load_addr,  // address for prog_load
   output logic             prog_clear,      // clear pc/sp/accu/x/flags
   output logic             exec_req,        // plain command, pulse
   output logic [7:0]       exec_op,         // its opcode
   output logic [7:0]       exec_type,       // its type
   output logic [7:0]       exec_bank,       // its motor/bank
   output logic [31:0]      exec_value,      // its value
   output logic             uf_req,          // user function, pulse
   output logic             factory_req,     // restore defaults, pulse
   output logic             swreset_req      // restart module, pulse
);
   // ==========================================================
   // reset release
   logic rst_meta_reg;
   logic rst_n_reg;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   localparam logic [63:0] fw_str = `MMC_FW_STRING;

   function automatic logic is_ctrl(input logic [7:0] op);
      is_ctrl = (op >= `MMC_OP_STOP && op <= `MMC_OP_POS_REQ)
                || op == `MMC_OP_SW_RESET;
   endfunction

   // ==========================================================
   // state
   mmc_pkg::mmc_mode_t mode_reg, mode_next;
   logic        dl_reg, dl_next;
   logic [15:0] ptr_reg, ptr_next;
   logic        once_reg, once_next;
   logic        always_reg, always_next;
   logic        watch_reg, watch_next;
   logic        arrive_reg, arrive_next;
   logic [7:0]  mask_reg, mask_next;
   logic        rv_reg, rv_next;
   logic [7:0]  rh_reg, rh_next, rt_reg, rt_next;
   logic [7:0]  rs_reg, rs_next, rc_reg, rc_next, rk_reg;
   logic [31:0] rval_reg, rval_next;
   logic        run_reg, run_next, load_reg, load_next;
   logic [15:0] laddr_reg, laddr_next;
   logic        clr_reg, clr_next, ex_reg, ex_next;
   logic [7:0]  xop_reg, xop_next, xty_reg, xty_next, xbk_reg, xbk_next;
   logic [31:0] xval_reg, xval_next;
   logic        uf_reg, uf_next, fac_reg, fac_next, swr_reg, swr_next;
   logic [55:0] prog_mem [`MMC_MEM_DEPTH];
   logic        mem_we;
   logic [55:0] mem_rd;
   logic [7:0]  cmd_sum, rpl_sum;

   mmc_sum8 u_cmd_sum (
      .b0  (cmd_target),
      .b1  (cmd_op),
      .b2  (cmd_type),
      .b3  (cmd_bank),
      .val (cmd_value),
      .sum (cmd_sum)
   );
   mmc_sum8 u_rpl_sum (
      .b0  (rh_next),
      .b1  (rt_next),
      .b2  (rs_next),
      .b3  (rc_next),
      .val (rval_next),
      .sum (rpl_sum)
   );

   assign mem_rd = prog_mem[cmd_value[7:0]];

   // ==========================================================
   // command decode
   always_comb begin
      mode_next = mode_reg;   dl_next = dl_reg;     ptr_next = ptr_reg;
      once_next = once_reg;   always_next = always_reg;
      watch_next = watch_reg; arrive_next = arrive_reg;
      mask_next = mask_reg;
      rv_next = 1'b0; rh_next = `MMC_HOST_ADDR; rt_next = `MMC_MODULE_ADDR;
      rs_next = `MMC_ST_OK; rc_next = cmd_op; rval_next = 32'h0;
      load_next = 1'b0; laddr_next = laddr_reg; clr_next = 1'b0;
      ex_next = 1'b0; xop_next = xop_reg; xty_next = xty_reg;
      xbk_next = xbk_reg; xval_next = xval_reg;
      uf_next = 1'b0; fac_next = 1'b0; swr_next = 1'b0; mem_we = 1'b0;
      if (prog_instr_done && mode_reg == mmc_pkg::MODE_STEP)
         mode_next = mmc_pkg::MODE_STOP;                       // see R13
      if (cmd_valid) begin
         rv_next = 1'b1;
         if (cmd_sum != cmd_cksum) begin
            rs_next = `MMC_ST_BAD_CKSUM;                       // see R22
         end else if (dl_reg && !is_ctrl(cmd_op)) begin   // see R9
            mem_we   = 1'b1;                                   // see R15
            ptr_next = 16'(ptr_reg + 16'h1);
         end else begin
            case (cmd_op)
               `MMC_OP_STOP: mode_next = mmc_pkg::MODE_STOP;   // see R11
               `MMC_OP_RUN: begin
                  if (cmd_type > 8'h1)
                     rs_next = `MMC_ST_BAD_TYPE;
                  else begin
                     mode_next  = mmc_pkg::MODE_RUN;           // see R12
                     load_next  = cmd_type[0];
                     laddr_next = cmd_type[0] ? cmd_value[15:0]
                                              : laddr_reg;
                  end
               end
               `MMC_OP_STEP: mode_next = mmc_pkg::MODE_STEP;   // see R13
               `MMC_OP_RESET: begin
                  mode_next = mmc_pkg::MODE_STOP;              // see R14
                  clr_next  = 1'b1;
               end
               `MMC_OP_DL_ENTER: begin
                  dl_next  = 1'b1;                             // see R15
                  ptr_next = cmd_value[15:0];
               end
               `MMC_OP_DL_EXIT: dl_next = 1'b0;                // see R16
               `MMC_OP_MEM_READ: begin
                  rc_next   = mem_rd[55:48];                   // see R17
                  rval_next = mem_rd[31:0];
               end
               `MMC_OP_STATUS: begin
                  case (cmd_type)                              // see R18
                     8'h0: rval_next = {6'h0, dl_reg ? 2'h3
                                        : 2'(mode_reg), 7'h0,
                                        prog_wait, ptr_reg};
                     8'h1: rval_next = {6'h0, dl_reg ? 2'h3
                                        : 2'(mode_reg), 7'h0,
                                        prog_wait, prog_pc};
                     8'h2: rval_next = prog_accu;
                     8'h3: rval_next = prog_xreg;
                     default: rs_next = `MMC_ST_BAD_TYPE;
                  endcase
               end
               `MMC_OP_VERSION: begin
                  if (cmd_type == 8'h0) begin                  // see R19
                     rh_next   = fw_str[63:56];
                     rt_next   = fw_str[55:48];
                     rs_next   = fw_str[47:40];
                     rc_next   = fw_str[39:32];
                     rval_next = fw_str[31:0];
                  end else if (cmd_type == 8'h1)
                     rval_next = `MMC_FW_BINARY;
                  else
                     rs_next = `MMC_ST_BAD_TYPE;
               end
               `MMC_OP_FACTORY: begin
                  if (cmd_value == `MMC_MAGIC) begin
                     rv_next  = 1'b0;                          // see R20
                     fac_next = 1'b1;
                  end else
                     rs_next = `MMC_ST_BAD_VALUE;
               end
               `MMC_OP_SW_RESET: begin
                  if (cmd_value == `MMC_MAGIC)
                     swr_next = 1'b1;                          // see R21
                  else
                     rs_next = `MMC_ST_BAD_VALUE;
               end
               `MMC_OP_POS_REQ: begin
                  if (dl_reg)
                     rs_next = `MMC_ST_BAD_CMD;                // see R3
                  else if (cmd_type > 8'h1)
                     rs_next = `MMC_ST_BAD_TYPE;
                  else begin
                     once_next   = ~cmd_type[0];               // see R5
                     always_next = cmd_type[0];                // see R6
                     mask_next   = cmd_value[7:0];
                     rval_next   = {24'h0, cmd_value[7:0]};    // see R7
                  end
               end
               default: begin
                  if (cmd_op >= `MMC_OP_UF_FIRST
                      && cmd_op <= `MMC_OP_UF_LAST) begin
                     uf_next   = 1'b1;                         // see R1
                     rval_next = uf_value;
                  end else begin
                     ex_next   = 1'b1;
                     xop_next  = cmd_op;
                     xty_next  = cmd_type;
                     xbk_next  = cmd_bank;
                     xval_next = cmd_value;
                     if (cmd_op == `MMC_OP_MOVE_POS
                         && (once_reg || always_reg)) begin
                        watch_next = 1'b1;                     // see R2
                        once_next  = 1'b0;                     // see R5
                     end
                  end
               end
            endcase
         end
      end else if (arrive_reg) begin
         rv_next     = 1'b1;                                   // see R8
         rs_next     = `MMC_ST_ARRIVED;
         rc_next     = `MMC_OP_POS_REQ;
         rval_next   = {24'h0, mask_reg};
         arrive_next = 1'b0;
      end
      // an arrival in the cycle the previous one is sent still counts
      if (pos_reached && watch_reg) begin
         arrive_next = 1'b1;                                   // see R2
         if (!(ex_next && cmd_op == `MMC_OP_MOVE_POS
               && (once_reg || always_reg)))
            watch_next = 1'b0;
      end
      run_next = (mode_next != mmc_pkg::MODE_STOP);
   end

   // ==========================================================
   // registers
   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         mode_reg <= mmc_pkg::MODE_STOP; dl_reg <= 1'b0; ptr_reg <= 16'h0;
         once_reg <= 1'b0; always_reg <= 1'b0; watch_reg <= 1'b0;
         arrive_reg <= 1'b0; mask_reg <= 8'h0;
         rv_reg <= 1'b0; rh_reg <= 8'h0; rt_reg <= 8'h0; rs_reg <= 8'h0;
         rc_reg <= 8'h0; rval_reg <= 32'h0; rk_reg <= 8'h0;
         run_reg <= 1'b0; load_reg <= 1'b0; laddr_reg <= 16'h0;
         clr_reg <= 1'b0; ex_reg <= 1'b0; xop_reg <= 8'h0;
         xty_reg <= 8'h0; xbk_reg <= 8'h0; xval_reg <= 32'h0;
         uf_reg <= 1'b0; fac_reg <= 1'b0; swr_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next; dl_reg <= dl_next; ptr_reg <= ptr_next;
         once_reg <= once_next; always_reg <= always_next;
         watch_reg <= watch_next; arrive_reg <= arrive_next;
         mask_reg <= mask_next;
         rv_reg <= rv_next; rh_reg <= rh_next; rt_reg <= rt_next;
         rs_reg <= rs_next; rc_reg <= rc_next; rval_reg <= rval_next;
         rk_reg <= rpl_sum;                                    // see R22
         run_reg <= run_next; load_reg <= load_next;
         laddr_reg <= laddr_next; clr_reg <= clr_next; ex_reg <= ex_next;
         xop_reg <= xop_next; xty_reg <= xty_next; xbk_reg <= xbk_next;
         xval_reg <= xval_next; uf_reg <= uf_next; fac_reg <= fac_next;
         swr_reg <= swr_next;
      end
   end

   always_ff @(posedge core_clk) begin
      if (mem_we)
         prog_mem[ptr_reg[7:0]] <= {cmd_op, cmd_type, cmd_bank, cmd_value};
   end

   assign rpl_valid = rv_reg;    assign rpl_host = rh_reg;
   assign rpl_target = rt_reg;   assign rpl_status = rs_reg;
   assign rpl_cmd = rc_reg;      assign rpl_value = rval_reg;
   assign rpl_cksum = rk_reg;    assign prog_run = run_reg;
   assign prog_load = load_reg;  assign prog_load_addr = laddr_reg;
   assign prog_clear = clr_reg;  assign exec_req = ex_reg;
   assign exec_op = xop_reg;     assign exec_type = xty_reg;
   assign exec_bank = xbk_reg;   assign exec_value = xval_reg;
   assign uf_req = uf_reg;       assign factory_req = fac_reg;
   assign swreset_req = swr_reg;

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n_reg);

   wire good = cmd_valid && cmd_sum == cmd_cksum;

   bad_cksum_a: assert property (cmd_valid && cmd_sum != cmd_cksum
      |=> rpl_valid && rpl_status == `MMC_ST_BAD_CKSUM && !exec_req) // see R22
      else $error("bad checksum frame not rejected");
   pos_reply_a: assert property (good && !dl_reg
      && cmd_op == `MMC_OP_POS_REQ && cmd_type <= 8'h1
      |=> rpl_status == `MMC_ST_OK && rpl_cmd == `MMC_OP_POS_REQ
      && rpl_value == {24'h0, $past(cmd_value[7:0])}) // see R7
      else $error("position request reply wrong");
   arrive_rpl_a: assert property (arrive_reg && !cmd_valid
      |=> rpl_valid && rpl_status == `MMC_ST_ARRIVED
      && rpl_cmd == `MMC_OP_POS_REQ && rpl_host == `MMC_HOST_ADDR) // see R8
      else $error("arrival reply wrong");
   one_shot_a: assert property (good && !dl_reg && once_reg
      && cmd_op == `MMC_OP_MOVE_POS |=> !once_reg && watch_reg) // see R5
      else $error("one-shot arming not consumed");
   keep_arm_a: assert property (good && !dl_reg && always_reg
      && cmd_op == `MMC_OP_MOVE_POS |=> always_reg && watch_reg) // see R6
      else $error("persistent arming lost");
   stop_halt_a: assert property (good && !dl_reg
      && cmd_op == `MMC_OP_STOP |=> !prog_run) // see R11
      else $error("stop did not halt");
   run_load_a: assert property (good && cmd_op == `MMC_OP_RUN
      && cmd_type == 8'h1 |=> prog_run && prog_load
      && prog_load_addr == $past(cmd_value[15:0])) // see R12
      else $error("run from address wrong");
   step_end_a: assert property (mode_reg == mmc_pkg::MODE_STEP
      && prog_instr_done && !cmd_valid |=> !prog_run) // see R13
      else $error("step did not stop");
   reset_clr_a: assert property (good && cmd_op == `MMC_OP_RESET
      |=> prog_clear && !prog_run ##1 !prog_clear) // see R14
      else $error("reset application wrong");
   dl_store_a: assert property (good && dl_reg && !is_ctrl(cmd_op)
      |=> !exec_req && !uf_req && ptr_reg == $past(ptr_reg) + 16'h1) // see R15
      else $error("download did not store");
   factory_a: assert property (good && cmd_op == `MMC_OP_FACTORY
      && cmd_value == `MMC_MAGIC |=> factory_req && !rpl_valid) // see R20
      else $error("factory restore wrong");
   swreset_a: assert property (good && cmd_op == `MMC_OP_SW_RESET
      && cmd_value == `MMC_MAGIC |=> swreset_req && rpl_valid) // see R21
      else $error("software reset wrong");
   uf_reply_a: assert property (good && !dl_reg
      && cmd_op inside {[`MMC_OP_UF_FIRST:`MMC_OP_UF_LAST]}
      |=> uf_req && rpl_status == `MMC_ST_OK) // see R1
      else $error("user function reply wrong");

   arrive_c: cover property (watch_reg && pos_reached ##[1:3] rpl_valid
      && rpl_status == `MMC_ST_ARRIVED);
   download_c: cover property (dl_reg && good ##1 !dl_reg);
   step_c: cover property (mode_reg == mmc_pkg::MODE_STEP
      ##[1:20] mode_reg == mmc_pkg::MODE_STOP);
endmodule

// file: tb/mmc_host_model.sv
/*
 * mmc_host_model.sv: host side of the command port; frames a command.
 * assumes: request fields held by the bench for one clock cycle.
 */
`timescale 1ns/1ns
module mmc_host_model (
   input  wire logic        req,        // send a frame this cycle
   input  wire logic        bad,        // corrupt the checksum
   input  wire logic [7:0]  op,         // opcode
   input  wire logic [7:0]  ty,         // type
   input  wire logic [31:0] val,        // value
   output logic             cmd_valid,  // frame present
   output logic [7:0]       cmd_target, // module address
   output logic [7:0]       cmd_op,     // opcode
   output logic [7:0]       cmd_type,   // type
   output logic [7:0]       cmd_bank,   // motor/bank
   output logic [31:0]      cmd_value,  // value
   output logic [7:0]       cmd_cksum   // byte sum
);
   // ==========================================================
   // frame assembly
   assign cmd_valid  = req;
   assign cmd_target = 8'h01;
   assign cmd_op     = req ? op : ~op;
   assign cmd_type   = ty;
   assign cmd_bank   = 8'h00;
   assign cmd_value  = val;
   assign cmd_cksum  = 8'(8'h01 + op + ty + val[31:24] + val[23:16]
                          + val[15:8] + val[7:0]) ^ {8{bad}};
endmodule

// file: tb/mmc_ctrl_tb.sv
/*
 * mmc_ctrl_tb.sv: self-checking bench of the command decoder.
 * assumes: mmc_ctrl and mmc_host_model compiled before it.
 */
`timescale 1ns/1ns
`include "mmc_map.svh"
module mmc_ctrl_tb;
   logic        core_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        req = 1'b0, bad = 1'b0, pos_reached = 1'b0;
   logic [7:0]  op = 8'h00, ty = 8'h00;
   logic [31:0] val = 32'h0, uf_value = 32'h0;
   logic [31:0] prog_accu = 32'h0, prog_xreg = 32'h0;
   logic        prog_instr_done = 1'b0, prog_wait = 1'b1;
   logic [15:0] prog_pc = 16'h0;
   wire         cmd_valid, rpl_valid, prog_run, prog_load, prog_clear;
   wire         exec_req, uf_req, factory_req, swreset_req;
   wire [7:0]   cmd_target, cmd_op, cmd_type, cmd_bank, cmd_cksum;
   wire [7:0]   rpl_host, rpl_target, rpl_status, rpl_cmd, rpl_cksum;
   wire [7:0]   exec_op, exec_type, exec_bank;
   wire [31:0]  cmd_value, rpl_value, exec_value;
   wire [15:0]  prog_load_addr;
   logic [48:0] exp_q[$];
   logic [48:0] e;
   int          fails = 0, tests_run = 0;

   always #25 core_clk = ~core_clk;

   mmc_host_model u_mmc_host_model (.req, .bad, .op, .ty, .val, .cmd_valid,
      .cmd_target, .cmd_op, .cmd_type, .cmd_bank, .cmd_value, .cmd_cksum);
   mmc_ctrl u_mmc_ctrl (.core_clk, .nrst, .cmd_valid, .cmd_target, .cmd_op,
      .cmd_type, .cmd_bank, .cmd_value, .cmd_cksum, .pos_reached,
      .prog_instr_done, .prog_wait, .prog_pc,
      .prog_accu, .prog_xreg, .uf_value, .rpl_valid, .rpl_host, .rpl_target,
      .rpl_status, .rpl_cmd, .rpl_value, .rpl_cksum, .prog_run, .prog_load,
      .prog_load_addr, .prog_clear, .exec_req, .exec_op, .exec_type,
      .exec_bank, .exec_value, .uf_req, .factory_req, .swreset_req);

   // ==========================================================
   // tasks
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task stop_test();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // status 00h means no reply is expected; c asks for a value compare
   task send(input logic [7:0] o, input logic [7:0] t, input logic [31:0] v,
             input logic b, input logic [7:0] st, input logic c,
             input logic [31:0] ev);
      @(negedge core_clk);
      op = o;
      ty = t;
      val = v;
      bad = b;
      req = 1'b1;
      if (st !== 8'h00)
         exp_q.push_back({c, st, o, ev});
      @(negedge core_clk);
      req = 1'b0;
   endtask

   task reach(input logic armed);
      if (armed)
         exp_q.push_back({1'b1, 8'h80, 8'h8A, 32'h1});
      @(negedge core_clk);
      pos_reached = 1'b1;
      @(negedge core_clk);
      pos_reached = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask

   task move(input logic armed);
      send(8'h04, 8'h00, $urandom(), 1'b0, 8'h64, 1'b0, 32'h0);
      check(exec_req, 1'b1);
      check(exec_value, val);
      check({exec_op, exec_type, exec_bank}, 24'h040000);
      reach(armed);
   endtask

   // ==========================================================
   // reply monitor
   always @(negedge core_clk) begin
      if (rpl_valid === 1'b1) begin
         if (exp_q.size() == 0)
            check(32'h1, 32'h0);
         else begin
            e = exp_q.pop_front();
            check(rpl_status, e[47:40]);
            check(rpl_cmd, e[39:32]);
            if (e[48])
               check(rpl_value, e[31:0]);
            check({rpl_host, rpl_target}, 16'h0201);
            check(rpl_cksum, 8'(8'h03 + rpl_status + rpl_cmd + rpl_value[31:24]
               + rpl_value[23:16] + rpl_value[15:8] + rpl_value[7:0]));
         end
      end
   end

   initial begin
      #(50 * 4000);
      fails++;
      stop_test();
   end

   // ==========================================================
   // scenarios
   initial begin
      void'($urandom(32'hEC9226A9));
      uf_value = $urandom();
      prog_accu = $urandom();
      prog_xreg = $urandom();
      prog_pc = 16'($urandom());
      repeat (10) @(negedge core_clk);
      nrst = 1'b1;
      repeat (3) @(negedge core_clk);
      send(8'h8A, 8'h01, 32'h1, 1'b0, 8'h64, 1'b1, 32'h1);
      move(1'b1);
      move(1'b1);
      send(8'h8A, 8'h00, 32'h1, 1'b0, 8'h64, 1'b1, 32'h1);
      move(1'b1);
      move(1'b0);
      for (int i = 0; i < 8; i++) begin
         send(8'(8'h40 + i), 8'(i), 32'h0, 1'b0, 8'h64, 1'b1, uf_value);
         check(uf_req, 1'b1);
      end
      send(8'h87, 8'h02, 32'h0, 1'b1, 8'h01, 1'b0, 32'h0);
      send(8'h87, 8'h02, 32'h0, 1'b0, 8'h64, 1'b1, prog_accu);
      send(8'h87, 8'h03, 32'h0, 1'b0, 8'h64, 1'b1, prog_xreg);
      send(8'h88, 8'h01, 32'h0, 1'b0, 8'h64, 1'b1, `MMC_FW_BINARY);
      send(8'h89, 8'h00, 32'h0, 1'b0, 8'h04, 1'b0, 32'h0);
      check(factory_req, 1'b0);
      send(8'h89, 8'h00, `MMC_MAGIC, 1'b0, 8'h00, 1'b0, 32'h0);
      check(factory_req, 1'b1);
      send(8'hFF, 8'h00, `MMC_MAGIC, 1'b0, 8'h64, 1'b0, 32'h0);
      check(swreset_req, 1'b1);
      send(8'h81, 8'h01, 32'h14, 1'b0, 8'h64, 1'b0, 32'h0);
      check({prog_run, prog_load, prog_load_addr}, 18'h30014);
      send(8'h80, 8'h00, 32'h0, 1'b0, 8'h64, 1'b0, 32'h0);
      check(prog_run, 1'b0);
      send(8'h82, 8'h00, 32'h0, 1'b0, 8'h64, 1'b0, 32'h0);
      check(prog_run, 1'b1);
      @(negedge core_clk);
      prog_instr_done = 1'b1;
      @(negedge core_clk);
      prog_instr_done = 1'b0;
      check(prog_run, 1'b0);
      send(8'h87, 8'h01, 32'h0, 1'b0, 8'h64, 1'b1,
           {15'h0, prog_wait, prog_pc});
      send(8'h83, 8'h00, 32'h0, 1'b0, 8'h64, 1'b0, 32'h0);
      check(prog_clear, 1'b1);
      send(8'h84, 8'h00, 32'h10, 1'b0, 8'h64, 1'b0, 32'h0);
      send(8'h05, 8'h02, 32'h1234ABCD, 1'b0, 8'h64, 1'b1, 32'h0);
      check(exec_req, 1'b0);
      send(8'h8A, 8'h01, 32'h1, 1'b0, 8'h02, 1'b0, 32'h0);
      send(8'h87, 8'h00, 32'h0, 1'b0, 8'h64, 1'b1, 32'h03010011);
      send(8'h85, 8'h00, 32'h0, 1'b0, 8'h64, 1'b0, 32'h0);
      exp_q.push_back({1'b1, 8'h64, 8'h05, 32'h1234ABCD});
      send(8'h86, 8'h00, 32'h10, 1'b0, 8'h00, 1'b0, 32'h0);
      move(1'b0);
      check(exp_q.size(), 32'h0);
      stop_test();
   end
endmodule
